// ---- logic/asc_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// R1 - Combined strobe: fall starts and reads
// R2 - Previous result shown while combined strobe low
// R3 - Host discards first access after power-up
// R4 - Long strobe: finish, update, no interrupt
// R5 - Wait output low during latch update
// R6 - Long write pulse: complete, interrupt stays high
// R7 - Chip select, read low: write converts, no interrupt
// R8 - Stand-alone: write driven by inverted wait
// R9 - Byte mode: write+read low gives high byte
// R10 - Second early pulse: low byte, restart
// R11 - Positive and negative samples four periods apart
// R12 - 4096 positive and 4096 negative codes
// R13 - Comparator strobed at end of period
// R14 - Byte pointer toggles per read, resets
// R15 - Interrupt released by read or write fall
// R16 - Status write resets sequencer and flags, not the output latch or data register
module asc_ctrl import asc_pkg::*; #(
   parameter bit BYTE_WIDE = 1'b0,
   parameter int DIV = CONV_DIV
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire asc_host_s host,
   input wire logic comp_hi,
   output asc_analog_s analog,
   output logic [RESULT_BITS-1:0] data_out_lines,
   output logic data_oe_n,
   output logic conversion_done_n,
   output logic ready_out_n
);

   function automatic logic [BYTE_BITS-1:0] pick_byte(input logic [RESULT_BITS-1:0] word,
                                                       input logic low_byte);
      if (low_byte) begin
         pick_byte = word[BYTE_BITS-1:0];
      end else begin
         pick_byte = {{3{word[RESULT_BITS-1]}}, word[RESULT_BITS-1:BYTE_BITS]};
      end
   endfunction

   asc_state_e state_reg;
   asc_state_e state_next;
   logic [2:0] gap_reg;
   logic sign_reg;
   logic [RESULT_BITS-1:0] latch_reg;
   logic [RESULT_BITS-1:0] data_reg;
   logic byte_low_reg;
   logic done_n_reg;
   logic eoc_reg;
   logic int_flag_reg;
   logic write_low_reg;
   logic read_low_reg;

   // Strobe decoding.
   wire write_low = !host.cs_n && !host.wr_n;
   wire read_low = !host.cs_n && !host.rd_n;
   wire status_sel = !host.status_n;
   wire write_fall = write_low && !write_low_reg;
   wire read_fall = read_low && !read_low_reg;
   wire status_write = write_low && status_sel;
   wire start = write_fall && !status_sel;
   wire data_read = read_fall && !status_sel;
   wire status_read = read_fall && status_sel;

   logic period_start;
   logic period_end;
   logic sar_last;
   logic [MAG_BITS-1:0] sar_trial;
   logic [MAG_BITS-1:0] sar_result;

   wire seq_clear = status_write || start;
   wire sample_tick = (state_reg == ASC_SAMPLE) && period_start;
   wire sign_decide = (state_reg == ASC_SIGN) && period_end;
   wire sar_step = (state_reg == ASC_SAR) && period_end;
   wire update_done = (state_reg == ASC_UPDATE) && period_end;
   // Interrupt is held off while a read or write strobe is still asserted at completion.
   wire irq_allowed = !write_low && !read_low;

   // The inverted magnitude gives -1 down to -4096 for negative inputs.
   wire [RESULT_BITS-1:0] conv_word = sign_reg ? ~{1'b0, sar_result} : {1'b0, sar_result}; // R12

   wire [RESULT_BITS-1:0] status_word = RESULT_BITS'({state_reg != ASC_IDLE, 3'b000,
                                                      byte_low_reg, eoc_reg, int_flag_reg});
   wire [RESULT_BITS-1:0] read_word = BYTE_WIDE ?
                                      RESULT_BITS'(pick_byte(latch_reg, byte_low_reg)) :
                                      latch_reg;

   asc_clk_div #(
      .DIV(DIV)
   ) u_div (
      .mclk(mclk),
      .reset_n(reset_n),
      .clear(seq_clear),
      .period_start(period_start),
      .period_end(period_end)
   );

   asc_sar #(
      .BITS(MAG_BITS)
   ) u_sar (
      .mclk(mclk),
      .reset_n(reset_n),
      .clear(seq_clear || sign_decide),
      .step(sar_step),
      .comp_hi(comp_hi),
      .trial(sar_trial),
      .result(sar_result),
      .last_step(sar_last)
   );

   // Sequencer next state; a start restarts from any state.
   always_comb begin
      state_next = state_reg;
      if (status_write) begin
         state_next = ASC_IDLE; // R16
      end else if (start) begin
         state_next = ASC_SAMPLE; // R1
      end else begin
         case (state_reg)
            ASC_IDLE: begin
               state_next = ASC_IDLE;
            end
            ASC_SAMPLE: begin
               if (sample_tick && gap_reg == 3'(SAMPLE_GAP)) begin
                  state_next = ASC_SIGN;
               end
            end
            ASC_SIGN: begin
               if (sign_decide) begin
                  state_next = ASC_SAR;
               end
            end
            ASC_SAR: begin
               if (sar_last) begin
                  state_next = ASC_UPDATE;
               end
            end
            ASC_UPDATE: begin
               if (update_done) begin
                  state_next = ASC_IDLE;
               end
            end
            default: begin
               state_next = ASC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= ASC_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Period counter between the two input samples.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         gap_reg <= 3'h0;
      end else if (seq_clear) begin
         gap_reg <= 3'h0;
      end else if (sample_tick) begin
         gap_reg <= gap_reg + 3'h1; // R11
      end
   end

   // Polarity is decided first, with the DAC at zero.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sign_reg <= 1'b0;
      end else if (seq_clear) begin
         sign_reg <= 1'b0;
      end else if (sign_decide) begin
         sign_reg <= !comp_hi;
      end
   end

   // Analog controls: samples at a period's leading edge, decisions at its end.
   assign analog.sample_pos = sample_tick && (gap_reg == 3'h0); // R11
   assign analog.sample_neg = sample_tick && (gap_reg == 3'(SAMPLE_GAP)); // R11
   assign analog.comp_strobe = sign_decide || sar_step; // R13
   assign analog.swap = sign_reg;
   assign analog.dac_code = (state_reg == ASC_SAR) ? sar_trial : '0;

   // Output latch is written only when a conversion completes.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         latch_reg <= RESULT_RST;
      end else if (update_done) begin
         latch_reg <= conv_word; // R4
      end
   end

   assign ready_out_n = !(state_reg == ASC_UPDATE); // R5

   // Byte pointer: toggles on every data read in byte mode only, high byte again after a conversion.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         byte_low_reg <= 1'b0;
      end else if (status_write || update_done) begin
         byte_low_reg <= 1'b0; // R14
      end else if (data_read && BYTE_WIDE) begin
         byte_low_reg <= !byte_low_reg; // R14
      end
   end

   // Data register: captured at a read's leading edge, held through the strobe unless a parallel-mode conversion completes under it.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         data_reg <= RESULT_RST;
      end else if (status_read) begin
         data_reg <= status_word;
      end else if (data_read) begin
         data_reg <= read_word; // R2 R9 R10
      end else if (read_low && !status_sel && !BYTE_WIDE && update_done) begin
         data_reg <= conv_word; // R7
      end
   end

   assign data_out_lines = data_reg;
   assign data_oe_n = !(read_low && read_low_reg);

   // Completion interrupt; a release in the same cycle as a completion wins.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         done_n_reg <= 1'b1;
      end else if (status_write) begin
         done_n_reg <= 1'b1; // R16
      end else if (update_done && irq_allowed) begin
         done_n_reg <= 1'b0;
      end else if (update_done) begin
         done_n_reg <= 1'b1; // R4 R6 R7
      end else if (write_fall || data_read) begin
         done_n_reg <= 1'b1; // R15
      end
   end

   assign conversion_done_n = done_n_reg;

   // Status bits.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         eoc_reg <= 1'b0;
         int_flag_reg <= 1'b0;
      end else if (status_write || start) begin
         eoc_reg <= 1'b0; // R16
         int_flag_reg <= 1'b0;
      end else if (update_done) begin
         eoc_reg <= 1'b1;
         int_flag_reg <= 1'b1;
      end else if (data_read || status_read) begin
         int_flag_reg <= 1'b0;
      end
   end

   // Previous strobe levels for edge detection.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         write_low_reg <= 1'b0;
         read_low_reg <= 1'b0;
      end else begin
         write_low_reg <= write_low;
         read_low_reg <= read_low;
      end
   end

endmodule
`default_nettype wire

// ---- common/asc_pkg.sv ----
package asc_pkg;

   // Clock figures: the system clock and the converter clock it is divided down to.
   localparam int MCLK_HZ = 200_000_000;
   localparam int CONV_CLK_HZ = 1_000_000;
   localparam int CONV_DIV = (MCLK_HZ + CONV_CLK_HZ - 1) / CONV_CLK_HZ;

   // Sample gap in converter clock periods, and word widths in bits.
   localparam int SAMPLE_GAP = 4;
   localparam int MAG_BITS = 12;
   localparam int RESULT_BITS = MAG_BITS + 1;
   localparam int BYTE_BITS = 8;

   // Status word bit positions, shown on a status read.
   localparam int ST_INT_BIT = 0;
   localparam int ST_EOC_BIT = 1;
   localparam int ST_BYTE_BIT = 2;
   localparam int ST_BUSY_BIT = 6;

   localparam logic [RESULT_BITS-1:0] RESULT_RST = 13'h0000;

   typedef enum logic [2:0] {
      ASC_IDLE = 3'b000,
      ASC_SAMPLE = 3'b001,
      ASC_SIGN = 3'b010,
      ASC_SAR = 3'b011,
      ASC_UPDATE = 3'b100
   } asc_state_e;

   // Host strobes, all active low.
   typedef struct packed {
      logic cs_n;
      logic wr_n;
      logic rd_n;
      logic status_n;
   } asc_host_s;

   // Controls toward the sampled-data comparator and DAC.
   typedef struct packed {
      logic sample_pos;
      logic sample_neg;
      logic comp_strobe;
      logic swap;
      logic [MAG_BITS-1:0] dac_code;
   } asc_analog_s;

endpackage

// ---- logic/asc_clk_div.sv ----
`timescale 1ns/100ps
`default_nettype none
module asc_clk_div import asc_pkg::*; #(
   parameter int DIV = CONV_DIV
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clear,
   output logic period_start,
   output logic period_end
);

   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   wire last = (cnt_reg == 16'(DIV - 1));

   assign cnt_next = last ? 16'h0000 : cnt_reg + 16'h0001;
   assign period_start = (cnt_reg == 16'h0000) && !clear;
   assign period_end = last && !clear;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg <= 16'h0000;
      end else if (clear) begin
         cnt_reg <= 16'h0000;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

endmodule
`default_nettype wire

// ---- logic/asc_sar.sv ----
`timescale 1ns/100ps
`default_nettype none
module asc_sar import asc_pkg::*; #(
   parameter int BITS = MAG_BITS
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clear,
   input wire logic step,
   input wire logic comp_hi,
   output logic [BITS-1:0] trial,
   output logic [BITS-1:0] result,
   output logic last_step
);

   logic [BITS-1:0] code_reg;
   logic [BITS-1:0] mask_reg;

   // The bit under test is added to the kept bits for the DAC.
   assign trial = code_reg | mask_reg;
   assign result = code_reg;
   assign last_step = step && mask_reg[0];

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         code_reg <= '0;
         mask_reg <= '0;
      end else if (clear) begin
         code_reg <= '0;
         mask_reg <= {1'b1, {(BITS-1){1'b0}}};
      end else if (step) begin
         if (comp_hi) begin
            code_reg <= code_reg | mask_reg;
         end
         mask_reg <= mask_reg >> 1;
      end
   end

endmodule
`default_nettype wire

// ---- verif/asc_cmp_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module asc_cmp_model import asc_pkg::*; (
   input wire asc_analog_s analog,
   input wire logic pos,
   input wire logic [MAG_BITS-1:0] mag,
   output logic comp_hi
);
   // A zero DAC code is the sign decision; every other code is a magnitude trial.
   assign comp_hi = (analog.dac_code == '0) ? pos : (mag >= analog.dac_code);
endmodule
`default_nettype wire

// ---- verif/asc_ctrl_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module asc_ctrl_chk import asc_pkg::*; #(
   parameter bit BYTE_WIDE = 1'b0,
   parameter int DIV = CONV_DIV
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire asc_host_s host,
   input wire logic comp_hi,
   input wire asc_analog_s analog,
   input wire logic [RESULT_BITS-1:0] data_out_lines,
   input wire logic data_oe_n,
   input wire logic conversion_done_n,
   input wire logic ready_out_n
);
   localparam int GAP = 4 * DIV;
   int lo_cnt;
   // Cycles since the last positive sample, zero once past GAP; a restart simply begins a new count.
   int pos_age;
   wire logic rd_on = !host.cs_n && !host.rd_n;
   wire logic wr_on = !host.cs_n && !host.wr_n;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         lo_cnt <= 0;
         pos_age <= 0;
      end else begin
         lo_cnt <= ready_out_n ? 0 : lo_cnt + 1;
         if (analog.sample_pos) begin
            pos_age <= 1;
         end else if (pos_age != 0 && pos_age <= GAP) begin
            pos_age <= pos_age + 1;
         end else begin
            pos_age <= 0;
         end
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   a_sample_gap: assert property (analog.sample_neg |-> pos_age == GAP)
      else $error("negative sample off its slot");
   a_strobe_pulse: assert property (analog.comp_strobe |=> !analog.comp_strobe)
      else $error("comparator strobe too long");
   a_ready_width: assert property ($rose(ready_out_n) |-> lo_cnt == DIV)
      else $error("ready low width wrong");
   a_done_after_update: assert property ($fell(conversion_done_n) |-> $past(!ready_out_n))
      else $error("done without update");
   a_no_int_held: assert property ($fell(conversion_done_n) |-> $past(!wr_on && !rd_on))
      else $error("done asserted under held strobe");
   a_release_wr: assert property (wr_on && $past(!wr_on) && host.status_n
      |-> ##[1:2] conversion_done_n)
      else $error("done not released by write");
   a_release_rd: assert property (rd_on && $past(!rd_on) && host.status_n
      |-> ##[1:2] conversion_done_n)
      else $error("done not released by read");
   a_oe_follows: assert property (rd_on && $past(rd_on) |-> !data_oe_n)
      else $error("outputs not enabled");
   a_oe_quiet: assert property (!rd_on |-> data_oe_n)
      else $error("outputs enabled without read");
   a_status_reset: assert property (wr_on && !host.status_n
      |=> conversion_done_n && ready_out_n)
      else $error("status write did not reset");
   a_start_sample: assert property (wr_on && $past(!wr_on) && host.status_n
      |-> ##[1:8] analog.sample_pos)
      else $error("write fall did not start");
   cover property (analog.sample_neg);
   cover property ($fell(conversion_done_n));
   cover property ($rose(ready_out_n) && wr_on);
endmodule
bind asc_ctrl asc_ctrl_chk #(.BYTE_WIDE(BYTE_WIDE), .DIV(DIV)) u_chk (.mclk(mclk),
   .reset_n(reset_n), .host(host), .comp_hi(comp_hi), .analog(analog),
   .data_out_lines(data_out_lines), .data_oe_n(data_oe_n),
   .conversion_done_n(conversion_done_n), .ready_out_n(ready_out_n));
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench import asc_pkg::*;;
   localparam int DV = 4;
   localparam logic [3:0] IDLE = 4'hf, WRT = 4'h3, RDS = 4'h5, BOTH = 4'h1, STW = 4'h2;
   logic mclk, reset_n, pos;
   logic [MAG_BITS-1:0] mag;
   asc_host_s host;
   asc_analog_s an [2];
   logic ch [2];
   logic [RESULT_BITS-1:0] dq [2];
   logic oe_n [2];
   logic done_n [2];
   logic rdy_n [2];
   logic [RESULT_BITS-1:0] w, w2;
   int n_fail, num_checks;
   for (genvar g = 0; g < 2; g++) begin : u
      asc_ctrl #(.BYTE_WIDE(g == 1), .DIV(DV)) dut (.mclk(mclk), .reset_n(reset_n),
         .host(host), .comp_hi(ch[g]), .analog(an[g]), .data_out_lines(dq[g]),
         .data_oe_n(oe_n[g]), .conversion_done_n(done_n[g]), .ready_out_n(rdy_n[g]));
      asc_cmp_model model (.analog(an[g]), .pos(pos), .mag(mag), .comp_hi(ch[g]));
   end
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk_word(input logic [12:0] got, input logic [12:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_word({12'h000, got}, {12'h000, exp});
   endtask
   task automatic drive(input logic [3:0] v, input int n);
      @(posedge mclk);
      host <= v;
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask
   // Waits for done (sel 0) or ready (sel 1) of the parallel unit to reach lvl.
   task automatic wait_sig(input bit sel, input logic lvl);
      for (int i = 0; i < 400; i++) begin
         @(negedge mclk);
         if ((sel ? rdy_n[0] : done_n[0]) === lvl) return;
      end
      n_fail++;
      $display("MISMATCH t=%0t wait expired sel=%h got=%h exp=%h", $time, sel,
               sel ? rdy_n[0] : done_n[0], lvl);
      tally_and_finish();
   endtask
   function automatic logic [12:0] expw(input logic p, input logic [11:0] m);
      return p ? {1'b0, m} : {1'b1, ~m};
   endfunction
   function automatic logic [12:0] hib(input logic [12:0] v);
      return {5'h00, {3{v[12]}}, v[12:8]};
   endfunction
   function automatic logic [12:0] lob(input logic [12:0] v);
      return {5'h00, v[7:0]};
   endfunction
   task automatic set_in(input logic p, input logic [11:0] m);
      pos = p;
      mag = m;
      w2 = w;
      w = expw(p, m);
   endtask
   task automatic t_separate();
      set_in(1'b1, 12'ha5c);
      drive(WRT, 2);
      drive(IDLE, 0);
      wait_sig(0, 1'b0);
      drive(RDS, 3);
      chk_word(dq[0], w);
      chk_word(dq[1], hib(w));
      chk_bit(done_n[0], 1'b1);
      drive(IDLE, 1);
      drive(RDS, 3);
      chk_word(dq[1], lob(w));
      drive(IDLE, 1);
   endtask
   task automatic t_long_wr();
      set_in(1'b0, 12'h3a1);
      drive(WRT, 1);
      wait_sig(1, 1'b0);
      chk_bit(an[0].swap, 1'b1);
      wait_sig(1, 1'b1);
      repeat (3) @(negedge mclk);
      chk_bit(done_n[0], 1'b1);
      drive(IDLE, 1);
      drive(RDS, 3);
      chk_word(dq[0], w);
      chk_word(dq[1], hib(w));
      drive(IDLE, 1);
   endtask
   task automatic t_combined();
      set_in(1'b1, 12'h7ff);
      drive(BOTH, 3);
      chk_word(dq[0], w2);
      chk_word(dq[1], lob(w2));
      wait_sig(1, 1'b0);
      wait_sig(1, 1'b1);
      repeat (3) @(negedge mclk);
      chk_bit(done_n[0], 1'b1);
      chk_word(dq[0], w);
      drive(IDLE, 1);
   endtask
   task automatic t_byte();
      set_in(1'b0, 12'h0c3);
      drive(BOTH, 2);
      chk_word(dq[1], hib(w2));
      drive(IDLE, 3);
      drive(BOTH, 2);
      chk_word(dq[1], lob(w2));
      drive(IDLE, 0);
      wait_sig(0, 1'b0);
      drive(RDS, 3);
      chk_word(dq[0], w);
      chk_word(dq[1], hib(w));
      drive(IDLE, 1);
   endtask
   task automatic t_rd_held();
      set_in(1'b1, 12'h800);
      drive(RDS, 2);
      drive(BOTH, 2);
      drive(RDS, 0);
      wait_sig(1, 1'b0);
      wait_sig(1, 1'b1);
      repeat (3) @(negedge mclk);
      chk_bit(done_n[0], 1'b1);
      chk_bit(oe_n[0], 1'b0);
      chk_word(dq[0], w);
      drive(IDLE, 1);
   endtask
   task automatic t_abort();
      drive(WRT, 2);
      drive(IDLE, 20);
      drive(STW, 2);
      drive(IDLE, 150);
      chk_bit(done_n[0], 1'b1);
      chk_bit(rdy_n[0], 1'b1);
   endtask
   task automatic t_loop();
      int n;
      n = 0;
      for (int k = 0; k < 300; k++) begin
         @(posedge mclk);
         host <= {1'b0, ~rdy_n[0], 2'b11};
         @(negedge mclk);
         if (an[0].sample_pos === 1'b1) n++;
      end
      chk_bit(n >= 3, 1'b1);
      drive(IDLE, 100);
   endtask
   initial begin
      host = IDLE;
      reset_n = 1'b0;
      n_fail = 0;
      num_checks = 0;
      w = '0;
      set_in(1'b1, 12'h000);
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      @(negedge mclk);
      chk_bit(done_n[0], 1'b1);
      chk_bit(oe_n[1], 1'b1);
      t_separate();
      t_long_wr();
      t_combined();
      t_byte();
      t_rd_held();
      t_abort();
      t_loop();
      tally_and_finish();
   end
endmodule
`default_nettype wire
